// ==== crr_asserts.sv ====
`timescale 1ns/1ns
module crr_asserts
   import crr_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Faults and supplies
   input wire crr_faults_t faults,
   input wire logic vpwr_above_por,
   input wire logic vdd_above_por,
   input wire logic vdd_in_range,
   input wire logic wake_reset_n_pin,
   // Outputs
   input wire logic [1:0] chan_allow,
   input wire logic fault_status_n_pin,
   input wire logic spi_port_enable,
   input wire logic por_event
);
   // Edges since reset; supply history is stale before three
   logic [1:0] up_ff;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         up_ff <= 2'h0;
      else if (up_ff != 2'h3)
         up_ff <= up_ff + 2'h1;
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ----------
   // Properties
   // ----------
   a_spi_kept_up:
      assert property ((|up_ff && vdd_in_range && wake_reset_n_pin)[*2]
         |-> spi_port_enable) else $error("spi port off");
   a_fault_off:
      assert property (faults.oc[0] && chan_allow[0] |=> !chan_allow[0])
         else $error("channel kept on in fault");
   a_uv_both_off:
      assert property (faults.uv |=> chan_allow == 2'h0)
         else $error("channel on in undervoltage");
   a_no_spurious:
      assert property (faults == 7'h00 |=>
         (chan_allow & $past(chan_allow)) == $past(chan_allow))
         else $error("channel off without fault");
   a_fsn_low:
      assert property (|faults |=> !fault_status_n_pin)
         else $error("fault pin high in fault");
   a_ot_waits:
      assert property (faults.ot[0] && !chan_allow[0] |=> !chan_allow[0])
         else $error("retry during overtemperature");
   a_fsn_recovers:
      assert property ((chan_allow == 2'h3 && faults == 7'h00) [*2]
         |=> fault_status_n_pin) else $error("fault pin stuck low");
   a_por_vdd_rise:
      assert property (up_ff == 2'h3 && wake_reset_n_pin
         && $rose(vdd_above_por) && !vpwr_above_por
         && !$past(vpwr_above_por) |=> por_event) else $error("no por");
   a_por_wake:
      assert property (up_ff == 2'h3 && $rose(wake_reset_n_pin)
         && (vpwr_above_por || vdd_above_por) |=> por_event)
         else $error("no por at wake");
   a_no_por_vpwr:
      assert property (up_ff == 2'h3 && $rose(vpwr_above_por)
         && vdd_above_por && $past(vdd_above_por)
         && $stable(wake_reset_n_pin) |=> !por_event)
         else $error("spurious por");
endmodule // crr_asserts
bind crr_top crr_asserts crr_asserts_i (.aclk, .aresetn, .faults,
   .vpwr_above_por, .vdd_above_por, .vdd_in_range, .wake_reset_n_pin,
   .chan_allow, .fault_status_n_pin, .spi_port_enable, .por_event);

// ==== crr_pkg.sv ====
// Function
// - Serial port stays usable in supply undervoltage while logic supply is normal.
// - In wake, one supply rising past POR with other low sets flag.
// - Entering wake with a supply already above POR sets the flag.
// - Power supply rising while logic supply stayed high gives no POR.
// - Only latchable faults retry; condition is oc or short or temp or uv.
// - Undervoltage and overtemperature retries wait until the cause is gone.
// - With retry disabled, latchable faults latch immediately.
// - Retry enabled when polarity bit equals the load-type input.
// - Retry starts when fault control is one and retry condition holds.
// - Channel switches on again when the selected retry period expires.
// - Fault gone: normal running, counter kept, fault bit kept until cleared.
// - Endless retry never latches the channel off.
// - Limited mode counts retries in four bits up to 15.
// - After 15 retries set the exhausted flag, allow one more retry.
// - Fault still present at final retry: latch off, fault pin low.
// - Delatch turns the channel on anytime and keeps the retry counter.
// - Retry counter reads back only in normal mode.
// - Counter clears on fail-safe, sleep exit, POR, endless set, disabling edge.
// - Latched channel cleared by endless set restarts after one period.
// - Lamp resets overcurrent duration each retry; motor at first clean PWM off.
package crr_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] OFS_CFG0 = 8'h00;
   localparam logic [7:0] OFS_CFG1 = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_CNT = 8'h0C;
   localparam logic [7:0] OFS_CMD = 8'h10;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam int CFG_POL_BIT = 0;
   localparam int CFG_ENDLESS_BIT = 1;
   localparam int CFG_PER_LSB = 2;
   localparam int STAT_FAULT_LSB = 0;
   localparam int STAT_FULL_LSB = 4;
   localparam int STAT_POR_BIT = 6;
   localparam int CNT_CH0_LSB = 4;
   localparam int CNT_CH1_LSB = 12;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_HZ = 20000000;
   localparam int TICK_US = 1000;
   localparam int TICK_CYCLES = (CLK_HZ / 1000000) * TICK_US;
   localparam logic [15:0] RETRY_MS0 = 16'h000A;
   localparam logic [15:0] RETRY_MS1 = 16'h0014;
   localparam logic [15:0] RETRY_MS2 = 16'h0028;
   localparam logic [15:0] RETRY_MS3 = 16'h0050;
   localparam logic [3:0] CNT_MAX = 4'hF;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      CRR_NORMAL,
      CRR_WAIT_CLEAR,
      CRR_WAIT_PER,
      CRR_LATCHED
   } crr_st_t;

   typedef struct packed {
      logic [1:0] oc;
      logic [1:0] sc;
      logic [1:0] ot;
      logic uv;
   } crr_faults_t;

   typedef struct packed {
      crr_st_t st;
      logic [7:0] cfg;
      logic [3:0] cnt;
      logic full;
      logic final_used;
      logic [15:0] timer;
      logic fault_bit;
      logic oc_arm;
      logic oc_rst;
   } crr_chan_t;

   typedef struct packed {
      crr_chan_t [1:0] ch;
      logic aw_hold;
      logic [7:0] awaddr;
      logic w_hold;
      logic [7:0] wdata;
      logic wstb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic vpwr_q;
      logic vdd_q;
      logic wake_q;
      logic por_flag;
      logic por_pulse;
      logic fsn;
      logic spi_en;
   } crr_state_t;

endpackage

// ==== crr_supply_model.sv ====
`timescale 1ns/1ns
module crr_supply_model
   import crr_pkg::*;
(
   // Clock
   input wire logic aclk,
   // Request: por sequence, wake, vdd ok, vdd por, vpwr por
   input wire logic [4:0] req,
   // Levels seen by the device
   output logic vpwr_above_por = 1'h1,
   output logic vdd_above_por = 1'h1,
   output logic vdd_in_range = 1'h1,
   output logic wake_reset_n_pin = 1'h1
);
   // Levels move one edge after the request, like slow supplies
   always @(posedge aclk)
   begin
      vpwr_above_por <= req[0];
      vdd_above_por <= req[1];
      vdd_in_range <= req[2];
      // Wake kept high in undervoltage, low one cycle to re-run POR
      wake_reset_n_pin <= req[3] & ~req[4];
   end
endmodule // crr_supply_model

// ==== crr_tick.sv ====
`timescale 1ns/1ns
module crr_tick
   import crr_pkg::*;
#(
   parameter int TICKS = TICK_CYCLES
)
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Enable pulse
   output logic tick
);

   typedef struct packed {
      logic [15:0] cnt;
      logic tick;
   } crr_tick_t;

   crr_tick_t tk_ff;
   crr_tick_t nxt_tk;

   // Free-running divider, one pulse per period
   always_comb
   begin
      nxt_tk = tk_ff;
      nxt_tk.tick = 1'b0;
      if (tk_ff.cnt == 16'(TICKS - 1))
      begin
         nxt_tk.cnt = 16'h0000;
         nxt_tk.tick = 1'b1;
      end
      else
      begin
         nxt_tk.cnt = tk_ff.cnt + 16'h0001;
      end
   end

   // State register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         tk_ff <= '0;
      else
         tk_ff <= nxt_tk;
   end

   assign tick = tk_ff.tick;

endmodule // crr_tick

// ==== crr_top.sv ====
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
module crr_top
   import crr_pkg::*;
#(
   parameter int TICKS = TICK_CYCLES
)
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] awaddr,
   // AXI4-Lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // AXI4-Lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read
   input wire logic arvalid,
   output logic arready,
   input wire logic [31:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Fault detectors and channel config
   input wire crr_faults_t faults,
   input wire logic [1:0] load_type_input,
   input wire logic [1:0] fault_control_signal,
   input wire logic [1:0] pwm_off_clean,
   // Supplies and modes
   input wire logic vpwr_above_por,
   input wire logic vdd_above_por,
   input wire logic vdd_in_range,
   input wire logic wake_reset_n_pin,
   input wire logic direct_in_high,
   input wire logic normal_mode,
   input wire logic fail_safe_entry,
   input wire logic sleep_exit,
   // Channel and status outputs
   output logic [1:0] chan_allow,
   output logic [1:0] oc_dur_reset,
   output logic fault_status_n_pin,
   output logic spi_port_enable,
   output logic por_event
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------

   // Retry period in ticks from the two select bits
   function automatic logic [15:0] per_ticks(input logic [1:0] sel);
      case (sel)
         2'h0: per_ticks = RETRY_MS0;
         2'h1: per_ticks = RETRY_MS1;
         2'h2: per_ticks = RETRY_MS2;
         default: per_ticks = RETRY_MS3;
      endcase
   endfunction

   // Retry enabled when polarity matches load type
   function automatic logic retry_on(input logic pol, input logic load);
      retry_on = (pol == load);
   endfunction

   // Known register offsets
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == OFS_CFG0) || (a == OFS_CFG1) || (a == OFS_STAT) ||
               (a == OFS_CNT) || (a == OFS_CMD);
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   crr_state_t s_ff;
   crr_state_t nxt_s;
   logic tick;

   // Millisecond enable for the retry timers
   crr_tick #(.TICKS(TICKS)) u_tick
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick)
   );

   // Bus handshakes, one transfer of each kind in flight
   assign awready = !s_ff.aw_hold && !s_ff.bvalid;
   assign wready = !s_ff.w_hold && !s_ff.bvalid;
   assign arready = !s_ff.rvalid;

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb
   begin
      logic do_wr;
      logic wake;
      logic por_ev;
      logic stat_rd;
      logic [7:0] ra;
      logic [31:0] rv;
      logic rc;
      logic heat;
      logic ena;
      logic wcfg;
      logic endless_set;
      logic dis_edge;
      logic dl;
      logic clr;
      logic any_bad;
      do_wr = 1'b0;
      wake = 1'b0;
      por_ev = 1'b0;
      stat_rd = 1'b0;
      ra = 8'h00;
      rv = 32'h00000000;
      rc = 1'b0;
      heat = 1'b0;
      ena = 1'b0;
      wcfg = 1'b0;
      endless_set = 1'b0;
      dis_edge = 1'b0;
      dl = 1'b0;
      clr = 1'b0;
      any_bad = 1'b0;
      nxt_s = s_ff;

      // Write address and data accepted in either order
      if (awvalid && awready)
      begin
         nxt_s.aw_hold = 1'b1;
         nxt_s.awaddr = awaddr[7:0];
      end
      if (wvalid && wready)
      begin
         nxt_s.w_hold = 1'b1;
         nxt_s.wdata = wdata[7:0];
         nxt_s.wstb = wstrb[0];
      end
      if (s_ff.bvalid && bready)
         nxt_s.bvalid = 1'b0;
      do_wr = s_ff.aw_hold && s_ff.w_hold && !s_ff.bvalid;
      if (do_wr)
      begin
         nxt_s.aw_hold = 1'b0;
         nxt_s.w_hold = 1'b0;
         nxt_s.bvalid = 1'b1;
         nxt_s.bresp = mapped(s_ff.awaddr) ? RESP_OKAY : RESP_SLVERR;
      end

      // Read mux; counters hidden outside normal mode
      ra = araddr[7:0];
      case (ra)
         OFS_CFG0: rv = {24'h000000, s_ff.ch[0].cfg};
         OFS_CFG1: rv = {24'h000000, s_ff.ch[1].cfg};
         OFS_STAT:
         begin
            rv[STAT_FAULT_LSB] = s_ff.ch[0].fault_bit;
            rv[STAT_FAULT_LSB + 1] = s_ff.ch[1].fault_bit;
            rv[STAT_FULL_LSB] = s_ff.ch[0].full;
            rv[STAT_FULL_LSB + 1] = s_ff.ch[1].full;
            rv[STAT_POR_BIT] = s_ff.por_flag;
         end
         OFS_CNT:
         begin
            if (normal_mode)
            begin
               rv[CNT_CH0_LSB +: 4] = s_ff.ch[0].cnt;
               rv[CNT_CH1_LSB +: 4] = s_ff.ch[1].cnt;
            end
         end
         default: rv = 32'h00000000;
      endcase
      if (s_ff.rvalid && rready)
         nxt_s.rvalid = 1'b0;
      if (arvalid && arready)
      begin
         nxt_s.rvalid = 1'b1;
         nxt_s.rdata = rv;
         nxt_s.rresp = mapped(ra) ? RESP_OKAY : RESP_SLVERR;
         stat_rd = (ra == OFS_STAT);
      end

      // Supply and wake edges for power-on-reset
      wake = wake_reset_n_pin || direct_in_high;
      nxt_s.vpwr_q = vpwr_above_por;
      nxt_s.vdd_q = vdd_above_por;
      nxt_s.wake_q = wake;
      if (wake)
      begin
         // One supply rises while the other stays low
         por_ev = (vpwr_above_por && !s_ff.vpwr_q && !vdd_above_por &&
                   !s_ff.vdd_q) ||
                  (vdd_above_por && !s_ff.vdd_q && !vpwr_above_por &&
                   !s_ff.vpwr_q);
         // Wake entry with a supply already up
         if (!s_ff.wake_q && ((vpwr_above_por && s_ff.vpwr_q) ||
                              (vdd_above_por && s_ff.vdd_q)))
            por_ev = 1'b1;
      end
      nxt_s.por_pulse = por_ev;
      // Read clears the flag; a same-cycle event still wins
      if (stat_rd)
         nxt_s.por_flag = 1'b0;
      if (por_ev)
         nxt_s.por_flag = 1'b1;

      // Serial port depends only on logic supply and wake pin
      nxt_s.spi_en = vdd_in_range && wake_reset_n_pin;

      // ----------------------------------------
      // Per-channel retry engines
      // ----------------------------------------
      for (int i = 0; i < 2; i++)
      begin
         rc = faults.oc[i] || faults.sc[i] || faults.ot[i] ||
              faults.uv;
         heat = faults.ot[i] || faults.uv;
         ena = retry_on(s_ff.ch[i].cfg[CFG_POL_BIT], load_type_input[i]);
         wcfg = do_wr && s_ff.wstb &&
                (s_ff.awaddr == ((i == 0) ? OFS_CFG0 : OFS_CFG1));
         endless_set = wcfg && !s_ff.ch[i].cfg[CFG_ENDLESS_BIT] &&
                       s_ff.wdata[CFG_ENDLESS_BIT];
         // Polarity edge that turns retry off
         dis_edge = wcfg && (s_ff.wdata[CFG_POL_BIT] !=
                             s_ff.ch[i].cfg[CFG_POL_BIT]) &&
                    (s_ff.wdata[CFG_POL_BIT] != load_type_input[i]);
         dl = do_wr && s_ff.wstb && (s_ff.awaddr == OFS_CMD) &&
              s_ff.wdata[i];
         clr = fail_safe_entry || sleep_exit || por_ev || endless_set ||
               dis_edge;
         nxt_s.ch[i].oc_rst = 1'b0;
         if (wcfg)
            nxt_s.ch[i].cfg = s_ff.wdata;

         case (s_ff.ch[i].st)
            CRR_NORMAL:
            begin
               if (rc)
               begin
                  if (!ena || !fault_control_signal[i])
                     nxt_s.ch[i].st = CRR_LATCHED;
                  else if (!s_ff.ch[i].cfg[CFG_ENDLESS_BIT] &&
                           s_ff.ch[i].final_used)
                     nxt_s.ch[i].st = CRR_LATCHED;
                  else
                  begin
                     // Timer restarts on every fault turn-off
                     nxt_s.ch[i].timer = 16'h0000;
                     nxt_s.ch[i].st = heat ? CRR_WAIT_CLEAR :
                                      CRR_WAIT_PER;
                  end
               end
            end
            CRR_WAIT_CLEAR:
            begin
               // Temperature and undervoltage must clear first
               if (!heat)
               begin
                  nxt_s.ch[i].timer = 16'h0000;
                  nxt_s.ch[i].st = CRR_WAIT_PER;
               end
            end
            CRR_WAIT_PER:
            begin
               if (tick && !heat)
               begin
                  if (s_ff.ch[i].timer + 16'h0001 >=
                      per_ticks(s_ff.ch[i].cfg[CFG_PER_LSB +: 2]))
                  begin
                     nxt_s.ch[i].st = CRR_NORMAL;
                     nxt_s.ch[i].oc_rst = !load_type_input[i];
                     nxt_s.ch[i].oc_arm = load_type_input[i];
                     if (!s_ff.ch[i].cfg[CFG_ENDLESS_BIT])
                     begin
                        if (s_ff.ch[i].full)
                           nxt_s.ch[i].final_used = 1'b1;
                        else
                        begin
                           nxt_s.ch[i].cnt = s_ff.ch[i].cnt + 4'h1;
                           if (s_ff.ch[i].cnt == CNT_MAX - 4'h1)
                              nxt_s.ch[i].full = 1'b1;
                        end
                     end
                  end
                  else
                     nxt_s.ch[i].timer = s_ff.ch[i].timer + 16'h0001;
               end
            end
            CRR_LATCHED:
            begin
               // Endless set delatches and waits one period
               if (endless_set && ena)
               begin
                  nxt_s.ch[i].timer = 16'h0000;
                  nxt_s.ch[i].st = CRR_WAIT_PER;
               end
            end
            default: nxt_s.ch[i].st = CRR_NORMAL;
         endcase

         // Delatch turns on at once and keeps the count
         if (dl && s_ff.ch[i].st != CRR_NORMAL)
            nxt_s.ch[i].st = CRR_NORMAL;

         // Motor: duration reset at first clean PWM turn-off
         if (s_ff.ch[i].oc_arm && pwm_off_clean[i])
         begin
            nxt_s.ch[i].oc_arm = 1'b0;
            nxt_s.ch[i].oc_rst = 1'b1;
         end

         if (clr)
         begin
            nxt_s.ch[i].cnt = 4'h0;
            nxt_s.ch[i].full = 1'b0;
            nxt_s.ch[i].final_used = 1'b0;
         end

         // Fault bit survives recovery until status read
         if (stat_rd)
            nxt_s.ch[i].fault_bit = 1'b0;
         if (rc)
            nxt_s.ch[i].fault_bit = 1'b1;
         if (rc || nxt_s.ch[i].st == CRR_LATCHED)
            any_bad = 1'b1;
      end

      // Pin high again once no fault and nothing latched
      nxt_s.fsn = !any_bad;
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_ff <= '0;
         s_ff.ch[0].cfg <= CFG_RST;
         s_ff.ch[1].cfg <= CFG_RST;
         s_ff.fsn <= 1'b1;
      end
      else
         s_ff <= nxt_s;
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign bvalid = s_ff.bvalid;
   assign bresp = s_ff.bresp;
   assign rvalid = s_ff.rvalid;
   assign rdata = s_ff.rdata;
   assign rresp = s_ff.rresp;
   assign chan_allow[0] = (s_ff.ch[0].st == CRR_NORMAL);
   assign chan_allow[1] = (s_ff.ch[1].st == CRR_NORMAL);
   assign oc_dur_reset[0] = s_ff.ch[0].oc_rst;
   assign oc_dur_reset[1] = s_ff.ch[1].oc_rst;
   assign fault_status_n_pin = s_ff.fsn;
   assign spi_port_enable = s_ff.spi_en;
   assign por_event = s_ff.por_pulse;

endmodule // crr_top

// ==== crr_top_bench.sv ====
`timescale 1ns/1ns
module crr_top_bench
   import crr_pkg::*;
;
   // Short tick keeps the retry periods to a few hundred cycles
   localparam int TK = 10;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic arvalid = 1'h0, rready = 1'h0, normal_mode = 1'h1;
   logic fail_safe_entry = 1'h0, sleep_exit = 1'h0, direct_in_high = 1'h0;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, chan_allow, oc_dur_reset;
   logic [31:0] rdata;
   crr_faults_t faults = 7'h00;
   logic [1:0] load_type_input = 2'h2, fault_control_signal = 2'h3;
   logic [1:0] pwm_off_clean = 2'h0;
   logic [4:0] sup_req = 5'h0F;
   logic vpwr_above_por, vdd_above_por, vdd_in_range, wake_reset_n_pin;
   logic fault_status_n_pin, spi_port_enable, por_event;
   int err_count = 0, total_checks = 0, por_cnt = 0;
   int odr_cnt [2] = '{0, 0};
   // ----------
   // Harness
   // ----------
   always #25 aclk = ~aclk;
   // Counters of the one-cycle outputs
   always @(posedge aclk)
   begin
      if (por_event === 1'h1)
         por_cnt <= por_cnt + 1;
      for (int c = 0; c < 2; c++)
         if (oc_dur_reset[c] === 1'h1)
            odr_cnt[c] <= odr_cnt[c] + 1;
   end
   crr_top #(.TICKS(TK)) crr_top_i (.aclk, .aresetn, .awvalid, .awready,
      .awaddr, .wvalid, .wready, .wdata, .wstrb(4'hF), .bvalid, .bready,
      .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
      .rresp, .faults, .load_type_input, .fault_control_signal,
      .pwm_off_clean, .vpwr_above_por, .vdd_above_por, .vdd_in_range,
      .wake_reset_n_pin, .direct_in_high, .normal_mode,
      .fail_safe_entry, .sleep_exit, .chan_allow, .oc_dur_reset,
      .fault_status_n_pin, .spi_port_enable, .por_event);
   crr_supply_model crr_supply_model_i (.aclk, .req(sup_req),
      .vpwr_above_por, .vdd_above_por, .vdd_in_range, .wake_reset_n_pin);
   // ----------
   // Shared tasks
   // ----------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("unexpected at %0t: got %0h want %0h", $time, g, e);
      end
   endtask
   // Both channels offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= {24'h000000, a};
      wdata <= {24'h000000, v};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do
      begin
         @(posedge aclk);
         n++;
         if (awvalid && awready)
            awvalid <= 1'h0;
         if (wvalid && wready)
            wvalid <= 1'h0;
         if (bready && bvalid)
         begin
            bready <= 1'h0;
            chk(bresp, RESP_OKAY);
         end
      end
      while ((awvalid || wvalid || bready) && n < 100);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= {24'h000000, a};
      arvalid <= 1'h1;
      rready <= 1'h1;
      do
      begin
         @(posedge aclk);
         n++;
         if (arvalid && arready)
            arvalid <= 1'h0;
         if (rready && rvalid)
         begin
            rready <= 1'h0;
            d = rdata;
            r = rresp;
         end
      end
      while ((arvalid || rready) && n < 100);
   endtask
   task automatic rdm(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(d & m, e);
   endtask
   task automatic hit(input logic [6:0] f, input int len);
      faults <= f;
      repeat (len) @(posedge aclk);
      faults <= 7'h00;
   endtask
   // Bounded wait for a channel to reach a level
   task automatic waitv(input int c, input logic v, input int mx,
      output int n);
      n = 0;
      while (chan_allow[c] !== v && n < mx)
      begin
         @(posedge aclk);
         n++;
      end
   endtask
   // ----------
   // Scenarios
   // ----------
   task automatic t_reset();
      logic [31:0] d;
      logic [1:0] r;
      rdm(OFS_STAT, 32'h40, 32'h00);
      rdm(OFS_STAT, 32'h40, 32'h00);
      rd(8'h14, d, r);
      chk(r, RESP_SLVERR);
      $display("t_reset done");
   endtask
   task automatic t_lamp();
      int n, p;
      logic [6:0] f [4] = '{7'h20, 7'h08, 7'h02, 7'h20};
      logic [15:0] per [4] = '{RETRY_MS0, RETRY_MS1, RETRY_MS2, RETRY_MS3};
      for (int s = 0; s < 4; s++)
      begin
         wr(OFS_CFG0, 8'(s * 4));
         hit(f[s], 4);
         waitv(0, 1'h0, 5, n);
         waitv(0, 1'h1, 2000, n);
         p = TK * int'(per[s]);
         chk(32'(n >= p - 2 * TK && n <= p + 2 * TK), 1);
      end
      rdm(OFS_STAT, 32'h01, 32'h01);
      rdm(OFS_CNT, 32'hF0, 32'h40);
      chk(odr_cnt[0], 4);
      normal_mode <= 1'h0;
      rdm(OFS_CNT, 32'hFFFF, 32'h0);
      normal_mode <= 1'h1;
      $display("t_lamp done");
   endtask
   task automatic t_limit();
      int n, m, k;
      wr(OFS_CFG0, 8'h00);
      faults <= 7'h20;
      n = 0;
      k = 0;
      while (n < 300 && k < 20)
      begin
         waitv(0, 1'h1, 300, n);
         waitv(0, 1'h0, 10, m);
         k++;
      end
      chk(fault_status_n_pin, 0);
      rdm(OFS_STAT, 32'h10, 32'h10);
      rdm(OFS_CNT, 32'hF0, 32'hF0);
      faults <= 7'h00;
      repeat (200) @(posedge aclk);
      chk(chan_allow[0], 0);
      wr(OFS_CMD, 8'h01);
      waitv(0, 1'h1, 5, n);
      chk(chan_allow[0], 1);
      rdm(OFS_CNT, 32'hF0, 32'hF0);
      hit(7'h20, 1);
      repeat (200) @(posedge aclk);
      chk(chan_allow[0], 0);
      wr(OFS_CFG0, 8'h02);
      rdm(OFS_CNT, 32'hF0, 32'h00);
      waitv(0, 1'h1, 200, n);
      chk(chan_allow[0], 1);
      faults <= 7'h20;
      for (int i = 0; i < 8; i++)
      begin
         waitv(0, 1'h1, 300, n);
         chk(32'(n < 300), 1);
         waitv(0, 1'h0, 10, n);
      end
      faults <= 7'h00;
      waitv(0, 1'h1, 300, n);
      $display("t_limit done");
   endtask
   task automatic t_motor();
      int n, k, p;
      hit(7'h40, 1);
      repeat (200) @(posedge aclk);
      chk(chan_allow[1], 0);
      wr(OFS_CFG1, 8'h01);
      wr(OFS_CMD, 8'h02);
      for (int e = 0; e < 4; e++)
      begin
         k = odr_cnt[1];
         p = por_cnt;
         hit(7'h40, 1);
         waitv(1, 1'h0, 5, n);
         waitv(1, 1'h1, 300, n);
         chk(32'(n < 300), 1);
         chk(odr_cnt[1], k);
         pwm_off_clean <= 2'h2;
         @(posedge aclk);
         pwm_off_clean <= 2'h0;
         rdm(OFS_CNT, 32'hF000, 32'h1000);
         chk(odr_cnt[1], k + 1);
         if (e == 3)
            wr(OFS_CFG1, 8'h00);
         fail_safe_entry <= (e == 0);
         sleep_exit <= (e == 1);
         sup_req[4] <= (e == 2);
         @(posedge aclk);
         fail_safe_entry <= 1'h0;
         sleep_exit <= 1'h0;
         sup_req[4] <= 1'h0;
         repeat (5) @(posedge aclk);
         rdm(OFS_CNT, 32'hF000, 32'h0);
         chk(por_cnt, p + (e == 2));
      end
      wr(OFS_CFG1, 8'h01);
      fault_control_signal <= 2'h1;
      hit(7'h40, 1);
      repeat (200) @(posedge aclk);
      chk(chan_allow[1], 0);
      fault_control_signal <= 2'h3;
      wr(OFS_CMD, 8'h02);
      $display("t_motor done");
   endtask
   task automatic t_supply();
      int p;
      p = por_cnt;
      faults <= 7'h01;
      sup_req <= 5'h0E;
      repeat (5) @(posedge aclk);
      chk(spi_port_enable, 1);
      chk(chan_allow, 0);
      rdm(OFS_CFG0, 32'hFF, 32'h02);
      faults <= 7'h00;
      sup_req <= 5'h0F;
      repeat (5) @(posedge aclk);
      chk(por_cnt, p);
      sup_req <= 5'h08;
      repeat (5) @(posedge aclk);
      sup_req <= 5'h0E;
      repeat (5) @(posedge aclk);
      chk(por_cnt, p + 1);
      sup_req <= 5'h07;
      repeat (2) @(posedge aclk);
      direct_in_high <= 1'h1;
      rdm(OFS_STAT, 32'h40, 32'h40);
      chk(por_cnt, p + 2);
      $display("t_supply done");
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Main sequence after ten reset cycles
   initial
   begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'h1;
      t_reset();
      t_lamp();
      t_limit();
      t_motor();
      t_supply();
      conclude();
   end
   // Watchdog well past the expected run
   initial
   begin
      #2000000;
      err_count++;
      conclude();
   end
endmodule // crr_top_bench
